/* core/iep_regs.sv */
`timescale 1ns/100ps
module iep_regs (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // Register port
  input  wire logic [2:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // Enable-gated sources
  input  wire logic [15:0] grp3_flag_i,
  input  wire logic [15:0] grp4_flag_i,
  output logic      [15:0] grp3_en_o,
  output logic      [15:0] grp4_en_o,
  output logic      [15:0] grp3_req_o,
  output logic      [15:0] grp4_req_o,
  // Level-ranked sources
  input  wire logic [11:0] lvl_flag_i,
  input  wire logic [11:0] lvl_src_en_i,
  output logic      [35:0] level_vec_o,
  // Arbitration result
  output logic             win_valid_o,
  output logic      [3:0]  win_slot_o,
  output logic      [2:0]  win_level_o
);

  logic [15:0] en3_reg;
  logic [15:0] en4_reg;
  logic [15:0] lvl_reg [iep_pkg::LVL_REGS];
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [15:0] req3_reg;
  logic [15:0] req4_reg;
  logic [11:0] slot_req;
  logic [2:0]  slot_lvl [iep_pkg::LVL_SLOTS];
  logic [2:0]  slot_cfg [iep_pkg::LVL_SLOTS];
  logic        win_valid_reg;
  logic [3:0]  win_slot_reg;
  logic [2:0]  win_level_reg;
  logic        win_valid_next;
  logic [3:0]  win_slot_next;
  logic [2:0]  win_level_next;

  // Enable group 3
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      en3_reg <= iep_pkg::EN_RST;
    else if (reg_wr_i && reg_addr_i == iep_pkg::EN3_IDX)
      en3_reg <= reg_wdata_i & iep_pkg::EN3_MASK;
  end

  // Enable group 4
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      en4_reg <= iep_pkg::EN_RST;
    else if (reg_wr_i && reg_addr_i == iep_pkg::EN4_IDX)
      en4_reg <= reg_wdata_i & iep_pkg::EN4_MASK;
  end

  // Level registers
  always_ff @(posedge ref_clk_i)
  begin
    for (int g = 0; g < iep_pkg::LVL_REGS; g++)
    begin
      if (!rst_b_i)
        lvl_reg[g] <= iep_pkg::LVL_RST;
      else if (reg_wr_i && reg_addr_i == 3'(iep_pkg::LVL0_IDX + 3'(g)))
        lvl_reg[g] <= reg_wdata_i & iep_pkg::LVL_MASK;
    end
  end

  // Enable gating of requests
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      req3_reg <= 16'h0000;
      req4_reg <= 16'h0000;
    end
    else
    begin
      req3_reg <= grp3_flag_i & en3_reg;
      req4_reg <= grp4_flag_i & en4_reg;
    end
  end

  // Level slots: slot i is field i%4 of level register i/4
  for (genvar i = 0; i < iep_pkg::LVL_SLOTS; i++)
  begin : g_slot
    assign slot_cfg[i] = lvl_reg[i / iep_pkg::LVL_FIELDS][iep_pkg::LVL_FIELD_LSB[i % iep_pkg::LVL_FIELDS] +:
                                                           iep_pkg::LVL_W];
    assign level_vec_o[i*iep_pkg::LVL_W +: iep_pkg::LVL_W] = slot_cfg[i];
    iep_level_slot u_slot (
      .flag_i   (lvl_flag_i[i]),
      .src_en_i (lvl_src_en_i[i]),
      .level_i  (slot_cfg[i]),
      .req_o    (slot_req[i]),
      .level_o  (slot_lvl[i])
    );
  end

  // Highest level wins; lowest slot on a tie
  always_comb
  begin
    win_valid_next = 1'b0;
    win_slot_next  = 4'h0;
    win_level_next = iep_pkg::LVL_OFF;
    for (int i = 0; i < iep_pkg::LVL_SLOTS; i++)
    begin
      if (slot_req[i] && slot_lvl[i] > win_level_next)
      begin
        win_valid_next = 1'b1;
        win_slot_next  = 4'(i);
        win_level_next = slot_lvl[i];
      end
    end
  end

  // Registered arbitration result
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      win_valid_reg <= 1'b0;
      win_slot_reg  <= 4'h0;
      win_level_reg <= iep_pkg::LVL_OFF;
    end
    else
    begin
      win_valid_reg <= win_valid_next;
      win_slot_reg  <= win_slot_next;
      win_level_reg <= win_level_next;
    end
  end

  // Read mux
  always_comb
  begin
    case (reg_addr_i)
      iep_pkg::EN3_IDX:  rdata_next = en3_reg;
      iep_pkg::EN4_IDX:  rdata_next = en4_reg;
      iep_pkg::LVL0_IDX: rdata_next = lvl_reg[0];
      iep_pkg::LVL1_IDX: rdata_next = lvl_reg[1];
      iep_pkg::LVL2_IDX: rdata_next = lvl_reg[2];
      default:           rdata_next = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      rdata_reg <= 16'h0000;
    else if (reg_rd_i)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= 16'h0000;
  end

  assign reg_rdata_o = rdata_reg;
  assign grp3_en_o   = en3_reg;
  assign grp4_en_o   = en4_reg;
  assign grp3_req_o  = req3_reg;
  assign grp4_req_o  = req4_reg;
  assign win_valid_o = win_valid_reg;
  assign win_slot_o  = win_slot_reg;
  assign win_level_o = win_level_reg;

  // Checks
  a_enable_gates_req:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      rst_b_i |=> (grp3_req_o == ($past(grp3_flag_i) & $past(grp3_en_o))
           && grp4_req_o == ($past(grp4_flag_i) & $past(grp4_en_o))))
    else $error("request not gated by enable");

  a_dma5_can_event:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_wr_i && reg_addr_i == iep_pkg::EN3_IDX) |=>
        (grp3_en_o[iep_pkg::DMA_CH5_DONE_EN] == $past(reg_wdata_i[iep_pkg::DMA_CH5_DONE_EN])
         && grp3_en_o[iep_pkg::CAN_B_EVENT_EN] == $past(reg_wdata_i[iep_pkg::CAN_B_EVENT_EN])))
    else $error("group 3 bits 13 or 8 wrong after write");

  a_can_rx_ext:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_wr_i && reg_addr_i == iep_pkg::EN3_IDX) |=>
        (grp3_en_o[iep_pkg::CAN_B_RX_READY_EN:iep_pkg::EXT_IRQ3_EN]
         == $past(reg_wdata_i[iep_pkg::CAN_B_RX_READY_EN:iep_pkg::EXT_IRQ3_EN])))
    else $error("group 3 bits 7 to 5 wrong after write");

  a_timer_enables:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_wr_i && reg_addr_i == iep_pkg::EN3_IDX) |=>
        (grp3_en_o[iep_pkg::TIMER9_EN:iep_pkg::TIMER8_EN]
         == $past(reg_wdata_i[iep_pkg::TIMER9_EN:iep_pkg::TIMER8_EN])))
    else $error("timer 9 or 8 enable wrong after write");

  a_i2c_timer7:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_wr_i && reg_addr_i == iep_pkg::EN3_IDX) ##1 reg_rd_i && reg_addr_i == iep_pkg::EN3_IDX |=>
        (reg_rdata_o[iep_pkg::I2C_B_MASTER_EN:iep_pkg::TIMER7_EN]
         == $past(reg_wdata_i[iep_pkg::I2C_B_MASTER_EN:iep_pkg::TIMER7_EN], 2)))
    else $error("group 3 bits 2 to 0 do not read back");

  a_unimpl_enable:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_rd_i && (reg_addr_i == iep_pkg::EN3_IDX || reg_addr_i == iep_pkg::EN4_IDX)) |=>
        ((reg_rdata_o & ~($past(reg_addr_i) == iep_pkg::EN3_IDX ? iep_pkg::EN3_MASK : iep_pkg::EN4_MASK))
         == 16'h0000))
    else $error("unimplemented enable bit reads nonzero");

  a_can_tx_enables:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_wr_i && reg_addr_i == iep_pkg::EN4_IDX) |=>
        (grp4_en_o[iep_pkg::CAN_B_TX_REQ_EN:iep_pkg::CAN_A_TX_REQ_EN]
         == $past(reg_wdata_i[iep_pkg::CAN_B_TX_REQ_EN:iep_pkg::CAN_A_TX_REQ_EN])))
    else $error("CAN transmit enables wrong after write");

  a_dma76_enables:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_wr_i && reg_addr_i == iep_pkg::EN4_IDX) |=>
        (grp4_en_o[iep_pkg::DMA_CH7_DONE_EN:iep_pkg::DMA_CH6_DONE_EN]
         == $past(reg_wdata_i[iep_pkg::DMA_CH7_DONE_EN:iep_pkg::DMA_CH6_DONE_EN])))
    else $error("DMA 7 or 6 enable wrong after write");

  a_uart_err_en:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_wr_i && reg_addr_i == iep_pkg::EN4_IDX) |=>
        (grp4_en_o[iep_pkg::UART_B_ERROR_EN:iep_pkg::UART_A_ERROR_EN]
         == $past(reg_wdata_i[iep_pkg::UART_B_ERROR_EN:iep_pkg::UART_A_ERROR_EN])))
    else $error("UART error enables wrong after write");

  a_win_level_match:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      rst_b_i ##1 win_valid_o |-> (win_level_o == $past(slot_cfg[win_slot_next]))
                          && $past(lvl_flag_i[win_slot_next]) && $past(lvl_src_en_i[win_slot_next]))
    else $error("winner level differs from its field");

  a_level_zero_off:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      win_valid_o |-> win_level_o != iep_pkg::LVL_OFF)
    else $error("disabled source reached arbitration");

  a_reset_values:
    assert property (@(posedge ref_clk_i)
      $rose(rst_b_i) |-> (grp3_en_o == iep_pkg::EN_RST && grp4_en_o == iep_pkg::EN_RST
                          && level_vec_o == {iep_pkg::LVL_SLOTS{iep_pkg::LVL_FIELD_RST}}))
    else $error("reset values wrong");

  a_timer1_field:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_wr_i && reg_addr_i == iep_pkg::LVL0_IDX) |=>
        (level_vec_o[2:0] == $past(reg_wdata_i[iep_pkg::TIMER1_LEVEL_LSB +: iep_pkg::LVL_W])
         && level_vec_o[11:9] == $past(reg_wdata_i[iep_pkg::EXT_IRQ0_LEVEL_LSB +: iep_pkg::LVL_W])))
    else $error("level group 0 field placement wrong");

  a_dma0_field:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_wr_i && reg_addr_i == iep_pkg::LVL1_IDX) |=>
        (level_vec_o[14:12] == $past(reg_wdata_i[iep_pkg::TIMER2_LEVEL_LSB +: iep_pkg::LVL_W])
         && level_vec_o[23:21] == $past(reg_wdata_i[iep_pkg::DMA_CH0_DONE_LEVEL_LSB +: iep_pkg::LVL_W])))
    else $error("level group 1 field placement wrong");

  a_uart_rx_field:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_wr_i && reg_addr_i == iep_pkg::LVL2_IDX) |=>
        (level_vec_o[26:24] == $past(reg_wdata_i[iep_pkg::UART_A_RX_LEVEL_LSB +: iep_pkg::LVL_W])
         && level_vec_o[35:33] == $past(reg_wdata_i[iep_pkg::TIMER3_LEVEL_LSB +: iep_pkg::LVL_W])))
    else $error("level group 2 field placement wrong");

  a_lvl_gap_bits:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_rd_i && reg_addr_i >= iep_pkg::LVL0_IDX && reg_addr_i <= iep_pkg::LVL2_IDX) |=>
        ((reg_rdata_o & ~iep_pkg::LVL_MASK) == 16'h0000))
    else $error("unimplemented level bit reads nonzero");

  a_highest_wins:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      rst_b_i |=> (win_valid_o == $past(|slot_req))
          && (!win_valid_o || ($past(slot_req[win_slot_next])
              && $past(slot_lvl[0]) <= win_level_o && $past(slot_lvl[11]) <= win_level_o)))
    else $error("arbitration did not pick highest level");

  a_cleared_blocks:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      rst_b_i |=>
        ((grp3_req_o & ~$past(grp3_en_o)) == 16'h0000
         && (grp4_req_o & ~$past(grp4_en_o)) == 16'h0000))
    else $error("cleared enable let a request through");

  a_group0_middle:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_wr_i && reg_addr_i == iep_pkg::LVL0_IDX) |=>
        (level_vec_o[5:3] == $past(reg_wdata_i[iep_pkg::COMPARE1_LEVEL_LSB +: iep_pkg::LVL_W])
         && level_vec_o[8:6] == $past(reg_wdata_i[iep_pkg::CAPTURE1_LEVEL_LSB +: iep_pkg::LVL_W])))
    else $error("level group 0 middle fields wrong");

  a_group1_middle:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_wr_i && reg_addr_i == iep_pkg::LVL1_IDX) |=>
        (level_vec_o[17:15] == $past(reg_wdata_i[iep_pkg::COMPARE2_LEVEL_LSB +: iep_pkg::LVL_W])
         && level_vec_o[20:18] == $past(reg_wdata_i[iep_pkg::CAPTURE2_LEVEL_LSB +: iep_pkg::LVL_W])))
    else $error("level group 1 middle fields wrong");

  a_group2_middle:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_wr_i && reg_addr_i == iep_pkg::LVL2_IDX) |=>
        (level_vec_o[29:27] == $past(reg_wdata_i[iep_pkg::SPI_A_EVENT_LEVEL_LSB +: iep_pkg::LVL_W])
         && level_vec_o[32:30] == $past(reg_wdata_i[iep_pkg::SPI_A_ERROR_LEVEL_LSB +: iep_pkg::LVL_W])))
    else $error("level group 2 middle fields wrong");

  a_en3_hold:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (rst_b_i && !(reg_wr_i && reg_addr_i == iep_pkg::EN3_IDX)) |=> $stable(grp3_en_o))
    else $error("enable group 3 changed without a write");

  a_en4_hold:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (rst_b_i && !(reg_wr_i && reg_addr_i == iep_pkg::EN4_IDX)) |=> $stable(grp4_en_o))
    else $error("enable group 4 changed without a write");

  a_level_hold:
    assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (rst_b_i && !(reg_wr_i && reg_addr_i >= iep_pkg::LVL0_IDX && reg_addr_i <= iep_pkg::LVL2_IDX))
        |=> $stable(level_vec_o))
    else $error("level fields changed without a write");

endmodule

/* core/iep_pkg.sv */
package iep_pkg;

  // Register bus geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;

  // Register indices on the plain register port
  localparam logic [2:0] EN3_IDX  = 3'h0;
  localparam logic [2:0] EN4_IDX  = 3'h1;
  localparam logic [2:0] LVL0_IDX = 3'h2;
  localparam logic [2:0] LVL1_IDX = 3'h3;
  localparam logic [2:0] LVL2_IDX = 3'h4;
  localparam int         LVL_REGS = 3;

  // Enable group 3 bit positions
  localparam int DMA_CH5_DONE_EN   = 13;
  localparam int CAN_B_EVENT_EN    = 8;
  localparam int CAN_B_RX_READY_EN = 7;
  localparam int EXT_IRQ4_EN       = 6;
  localparam int EXT_IRQ3_EN       = 5;
  localparam int TIMER9_EN         = 4;
  localparam int TIMER8_EN         = 3;
  localparam int I2C_B_MASTER_EN   = 2;
  localparam int I2C_B_SLAVE_EN    = 1;
  localparam int TIMER7_EN         = 0;

  // Enable group 4 bit positions
  localparam int CAN_B_TX_REQ_EN = 7;
  localparam int CAN_A_TX_REQ_EN = 6;
  localparam int DMA_CH7_DONE_EN = 5;
  localparam int DMA_CH6_DONE_EN = 4;
  localparam int UART_B_ERROR_EN = 2;
  localparam int UART_A_ERROR_EN = 1;

  // Implemented bits; all others read zero and ignore writes
  localparam logic [15:0] EN3_MASK = 16'((1 << DMA_CH5_DONE_EN) | (1 << CAN_B_EVENT_EN)
    | (1 << CAN_B_RX_READY_EN) | (1 << EXT_IRQ4_EN) | (1 << EXT_IRQ3_EN) | (1 << TIMER9_EN)
    | (1 << TIMER8_EN) | (1 << I2C_B_MASTER_EN) | (1 << I2C_B_SLAVE_EN) | (1 << TIMER7_EN));
  localparam logic [15:0] EN4_MASK = 16'((1 << CAN_B_TX_REQ_EN) | (1 << CAN_A_TX_REQ_EN)
    | (1 << DMA_CH7_DONE_EN) | (1 << DMA_CH6_DONE_EN) | (1 << UART_B_ERROR_EN)
    | (1 << UART_A_ERROR_EN));
  localparam logic [15:0] EN_RST   = 16'h0000;

  // Level field positions, same layout in all three level registers
  localparam int TIMER1_LEVEL_LSB       = 12;
  localparam int COMPARE1_LEVEL_LSB     = 8;
  localparam int CAPTURE1_LEVEL_LSB     = 4;
  localparam int EXT_IRQ0_LEVEL_LSB     = 0;
  localparam int TIMER2_LEVEL_LSB       = TIMER1_LEVEL_LSB;
  localparam int COMPARE2_LEVEL_LSB     = COMPARE1_LEVEL_LSB;
  localparam int CAPTURE2_LEVEL_LSB     = CAPTURE1_LEVEL_LSB;
  localparam int DMA_CH0_DONE_LEVEL_LSB = EXT_IRQ0_LEVEL_LSB;
  localparam int UART_A_RX_LEVEL_LSB    = TIMER1_LEVEL_LSB;
  localparam int SPI_A_EVENT_LEVEL_LSB  = COMPARE1_LEVEL_LSB;
  localparam int SPI_A_ERROR_LEVEL_LSB  = CAPTURE1_LEVEL_LSB;
  localparam int TIMER3_LEVEL_LSB       = EXT_IRQ0_LEVEL_LSB;
  localparam int LVL_FIELDS             = 4;
  localparam int LVL_SLOTS              = LVL_REGS * LVL_FIELDS;
  localparam int LVL_FIELD_LSB [LVL_FIELDS] = '{TIMER1_LEVEL_LSB, COMPARE1_LEVEL_LSB,
                                               CAPTURE1_LEVEL_LSB, EXT_IRQ0_LEVEL_LSB};

  // Level encoding
  localparam int         LVL_W         = 3;
  localparam logic [2:0] LVL_OFF       = 3'h0;
  localparam logic [2:0] LVL_FIELD_RST = 3'h4;
  localparam logic [2:0] LVL_FIELD_ONE = 3'h7;
  localparam logic [15:0] LVL_MASK = 16'({4{1'b0, LVL_FIELD_ONE}});
  localparam logic [15:0] LVL_RST  = 16'({4{1'b0, LVL_FIELD_RST}});

  // Slot number width for the arbitration result
  localparam int SLOT_W = 4;

endpackage

/* core/iep_level_slot.sv */
`timescale 1ns/100ps
module iep_level_slot (
  // Source state
  input  wire logic       flag_i,
  input  wire logic       src_en_i,
  input  wire logic [2:0] level_i,
  // Arbitration view
  output logic            req_o,
  output logic [2:0]      level_o
);

  // Presented only when flagged, enabled and not disabled by level zero
  always_comb
  begin
    req_o   = flag_i && src_en_i && (level_i != iep_pkg::LVL_OFF);
    level_o = req_o ? level_i : iep_pkg::LVL_OFF;
  end

endmodule

/* dv/iep_src_model.sv */
`timescale 1ns/100ps
module iep_src_model (
  // Clock
  input  wire logic        ref_clk_i,
  // Raise patterns from the bench
  input  wire logic [15:0] grp3_raise_i,
  input  wire logic [15:0] grp4_raise_i,
  input  wire logic [11:0] lvl_raise_i,
  // Source flags toward the controller
  output logic      [15:0] grp3_flag_o,
  output logic      [15:0] grp4_flag_o,
  output logic      [11:0] lvl_flag_o
);
  // Sources raise and drop flags one cycle after the pattern changes
  always_ff @(posedge ref_clk_i)
  begin
    grp3_flag_o <= grp3_raise_i;
    grp4_flag_o <= grp4_raise_i;
    lvl_flag_o  <= lvl_raise_i;
  end
endmodule

/* dv/irq_enable_priority_regs_test.sv */
`timescale 1ns/100ps
module irq_enable_priority_regs_test;
  typedef struct {
    logic [2:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } iep_row_t;

  logic        ref_clk_i;
  logic        rst_b_i;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] grp3_raise;
  logic [15:0] grp4_raise;
  logic [11:0] lvl_raise;
  logic [11:0] lvl_src_en;
  logic [15:0] grp3_flag;
  logic [15:0] grp4_flag;
  logic [11:0] lvl_flag;
  logic [15:0] grp3_en;
  logic [15:0] grp4_en;
  logic [15:0] grp3_req;
  logic [15:0] grp4_req;
  logic [35:0] level_vec;
  logic        win_valid;
  logic [3:0]  win_slot;
  logic [2:0]  win_level;
  int          n_errors;
  int          samples_checked;
  int          cycles;

  iep_row_t rows [9] = '{
    '{iep_pkg::EN3_IDX,  16'hFFFF, 16'h21FF},
    '{iep_pkg::EN4_IDX,  16'hFFFF, 16'h00F6},
    '{iep_pkg::LVL0_IDX, 16'hFFFF, 16'h7777},
    '{iep_pkg::LVL0_IDX, 16'h0305, 16'h0305},
    '{iep_pkg::LVL1_IDX, 16'h8888, 16'h0000},
    '{iep_pkg::LVL1_IDX, 16'h5007, 16'h5007},
    '{iep_pkg::LVL2_IDX, 16'h9000, 16'h1000},
    '{3'h5,              16'hFFFF, 16'h0000},
    '{3'h7,              16'hFFFF, 16'h0000}
  };
  logic [15:0] lvl_words [3] = '{16'h0305, 16'h5007, 16'h1000};

  iep_regs u_iep_regs (
    .ref_clk_i    (ref_clk_i),
    .rst_b_i      (rst_b_i),
    .reg_addr_i   (reg_addr),
    .reg_wdata_i  (reg_wdata),
    .reg_wr_i     (reg_wr),
    .reg_rd_i     (reg_rd),
    .reg_rdata_o  (reg_rdata),
    .grp3_flag_i  (grp3_flag),
    .grp4_flag_i  (grp4_flag),
    .grp3_en_o    (grp3_en),
    .grp4_en_o    (grp4_en),
    .grp3_req_o   (grp3_req),
    .grp4_req_o   (grp4_req),
    .lvl_flag_i   (lvl_flag),
    .lvl_src_en_i (lvl_src_en),
    .level_vec_o  (level_vec),
    .win_valid_o  (win_valid),
    .win_slot_o   (win_slot),
    .win_level_o  (win_level)
  );

  iep_src_model u_iep_src_model (
    .ref_clk_i    (ref_clk_i),
    .grp3_raise_i (grp3_raise),
    .grp4_raise_i (grp4_raise),
    .lvl_raise_i  (lvl_raise),
    .grp3_flag_o  (grp3_flag),
    .grp4_flag_o  (grp4_flag),
    .lvl_flag_o   (lvl_flag)
  );

  initial
  begin
    ref_clk_i = 1'h0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic conclude;
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge ref_clk_i);
    reg_wr    <= 1'h0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] q);
    @(posedge ref_clk_i);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge ref_clk_i);
    reg_rd   <= 1'h0;
    #1;
    q = reg_rdata;
  endtask

  task automatic settle;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic arb(input logic [11:0] f, input logic [11:0] e, input logic [7:0] exp);
    @(posedge ref_clk_i);
    lvl_raise  <= f;
    lvl_src_en <= e;
    settle();
    chk("winner", {28'h0, exp}, {28'h0, win_valid, win_slot, win_level});
  endtask

  // Hang guard
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      conclude();
    end
  end

  initial
  begin
    logic [15:0] q;
    logic [35:0] exp_vec;
    rst_b_i = 1'h0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    grp3_raise = 16'h0000;
    grp4_raise = 16'h0000;
    lvl_raise = 12'h000;
    lvl_src_en = 12'hFFF;
    repeat (12) @(posedge ref_clk_i);
    rst_b_i <= 1'h1;
    #1;
    chk("en3 reset", 36'h0, {20'h0, grp3_en});
    chk("level reset", {12{3'h4}}, level_vec);
    rd(iep_pkg::EN4_IDX, q);
    chk("en4 reset read", 36'h0, {20'h0, q});
    rd(iep_pkg::LVL2_IDX, q);
    chk("level reset read", 36'h4444, {20'h0, q});
    @(posedge ref_clk_i);
    #1;
    chk("rdata idle", 36'h0, {20'h0, reg_rdata});
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, q);
      chk("readback", {20'h0, rows[i].e}, {20'h0, q});
    end
    exp_vec = 36'h0;
    for (int r = 0; r < 3; r++)
      for (int f = 0; f < 4; f++)
        exp_vec[3*(4*r+f) +: 3] = lvl_words[r][iep_pkg::LVL_FIELD_LSB[f] +: 3];
    chk("level vector", exp_vec, level_vec);
    @(posedge ref_clk_i);
    grp3_raise <= 16'hFFFF;
    grp4_raise <= 16'hFFFF;
    settle();
    chk("grp3 req", 36'h21FF, {20'h0, grp3_req});
    chk("grp4 req", 36'h00F6, {20'h0, grp4_req});
    wr(iep_pkg::EN3_IDX, 16'h2000);
    settle();
    chk("grp3 req narrowed", 36'h2000, {20'h0, grp3_req});
    chk("grp3 en", 36'h2000, {20'h0, grp3_en});
    arb(12'h008, 12'hFFF, {1'h1, 4'h3, 3'h5});
    arb(12'h018, 12'hFFF, {1'h1, 4'h3, 3'h5});
    arb(12'h098, 12'hFFF, {1'h1, 4'h7, 3'h7});
    arb(12'h098, 12'hF7F, {1'h1, 4'h3, 3'h5});
    arb(12'h005, 12'hFFF, 8'h00);
    arb(12'h102, 12'hFFF, {1'h1, 4'h1, 3'h3});
    arb(12'h100, 12'hFFF, {1'h1, 4'h8, 3'h1});
    arb(12'h098, 12'hFFF, {1'h1, 4'h7, 3'h7});
    // Write then read with no gap
    @(posedge ref_clk_i);
    reg_addr  <= iep_pkg::EN3_IDX;
    reg_wdata <= 16'hDE05;
    reg_wr    <= 1'h1;
    @(posedge ref_clk_i);
    reg_wr    <= 1'h0;
    reg_rd    <= 1'h1;
    @(posedge ref_clk_i);
    reg_rd    <= 1'h0;
    #1;
    chk("back to back read", 36'h0005, {20'h0, reg_rdata});
    @(posedge ref_clk_i);
    rst_b_i <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("en4 mid reset", 36'h0, {20'h0, grp4_en});
    chk("level mid reset", {12{3'h4}}, level_vec);
    chk("win mid reset", 36'h0, {28'h0, win_valid, win_slot, win_level});
    @(posedge ref_clk_i);
    rst_b_i <= 1'h1;
    settle();
    chk("grp3 req after reset", 36'h0, {20'h0, grp3_req});
    chk("win after reset", {28'h0, 1'h1, 4'h3, 3'h4}, {28'h0, win_valid, win_slot, win_level});
    conclude();
  end
endmodule
